// ==== design/gdp_defines.svh ====
// constants for the grayscale dimming and precharge generator
`ifndef GDP_DEFINES_SVH
`define GDP_DEFINES_SVH
`define GDP_NUM_CH        16
`define GDP_GS_W          12
`define GDP_DC_W          6
`define GDP_PERIOD        13'h1000
`define GDP_TRACK_CYCLES  12'hE00
`define GDP_PRECH_CYCLES  12'h200
`define GDP_GS_RESET      12'h000
`define GDP_DC_RESET      6'h00
`define GDP_CNT_RESET     12'h000
`endif

// ==== design/gdp_pkg.sv ====
// types for the grayscale dimming and precharge generator
`include "gdp_defines.svh"
package gdp_pkg;
    typedef logic [`GDP_GS_W-1:0] gdp_gs_t;
    typedef logic [`GDP_DC_W-1:0] gdp_dc_t;
    typedef gdp_gs_t [`GDP_NUM_CH-1:0] gdp_gs_arr_t;
    typedef gdp_dc_t [`GDP_NUM_CH-1:0] gdp_dc_arr_t;
    typedef enum logic [1:0]
    {
        GDP_STARTUP  = 2'b00,
        GDP_TRACKING = 2'b01,
        GDP_PRECHARGE_PHASE   = 2'b10
    } gdp_phase_t;
endpackage : gdp_pkg

// ==== design/gdp_cnt_if.sv ====
// shared counter signals between the generator top and its counter
`timescale 1ns/100ps
`default_nettype none
interface gdp_cnt_if;
    import gdp_pkg::*;
    gdp_gs_t count;
    logic    step;
    logic    running;
    modport ctr (output count, output step, output running);
    modport top (input count, input step, input running);
endinterface : gdp_cnt_if
`default_nettype wire

// ==== design/gdp_counter.sv ====
// shared 12-bit grayscale counter
`timescale 1ns/100ps
`default_nettype none
`include "gdp_defines.svh"
module gdp_counter
(
    input  wire logic core_clk_i,   // system clock
    input  wire logic resetn_i,     // async reset, active low
    input  wire logic enable_i,     // global enable bit
    input  wire logic dim_rise_i,   // dimming clock rising edge pulse
    gdp_cnt_if.ctr    cnt           // counter outputs
);
    import gdp_pkg::*;

    gdp_gs_t count;
    gdp_gs_t next_count;
    logic    running;
    logic    next_running;

    always_comb
    begin
        next_count   = count;
        next_running = running;
        if (!enable_i)
        begin
            next_count   = `GDP_CNT_RESET;               // [R5]
            next_running = 1'b0;
        end
        else if (dim_rise_i)
        begin
            next_count   = count + 12'h001;              // [R2] [R3] [R16]
            next_running = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            count   <= `GDP_CNT_RESET;
            running <= 1'b0;
        end
        else
        begin
            count   <= next_count;
            running <= next_running;
        end
    end

    assign cnt.count   = count;
    assign cnt.step    = enable_i && dim_rise_i;
    assign cnt.running = running;
endmodule : gdp_counter
`default_nettype wire

// ==== design/gdp_top.sv ====
// sixteen-channel grayscale dimming generator with precharge phase
`timescale 1ns/100ps
`default_nettype none
`include "gdp_defines.svh"
// Overview of operation
// [R1] each channel repeats every 4096 dimming clocks with duty equal to its level over 4096; the code gives its level minus one over 4096.
// [R2] the first dimming edge after enable moves the counter from zero to one and lights nonzero channels; the code leaves a level-one channel off.
// [R3] every further dimming edge while enabled adds exactly one to the counter.
// [R4] a channel turns off when the counter equals its grayscale level.
// [R5] clearing enable zeroes the counter and turns all channels off at once.
// [R6] all channels share one counter, so periods and rising edges coincide.
// [R7] each current sink is enabled exactly while its dimming waveform is high.
// [R8] the controller may stop the dimming clock to hold channels on indefinitely.
// [R9] precharge phase is low for the first 3584 cycles of a period and high for the last 512; the code holds it high from count 3584 through count zero.
// [R10] if all channels are inactive before cycle 3585 the precharge phase rises at once.
// [R11] low precharge selects the led loop amplifier, high hands control to the feedback loop.
// [R12] during startup the led loop amplifier stays disabled.
// [R13] each channel holds a 6-bit dot correction code driving its current dac.
// [R14] reset clears frame select, enable, all levels and all codes.
// [R15] a load updates levels when frame select is zero, codes when one, and always enable.
// [R16] after the 4096th dimming edge the counter wraps, relighting nonzero channels, precharge low; the code relights and drops precharge on the 4097th edge.
module gdp_top
(
    input  wire logic                core_clk_i,        // system clock, 250 MHz
    input  wire logic                resetn_i,          // power-on reset, active low
    input  wire logic                dimming_clock_i,   // dimming clock, synchronous
    input  wire logic                load_i,            // frame load strobe
    input  wire logic                frame_select_bit_i,// received frame select
    input  wire logic                enable_bit_i,      // received enable bit
    input  wire gdp_pkg::gdp_gs_arr_t frame_gs_i,       // received grayscale levels
    input  wire gdp_pkg::gdp_dc_arr_t frame_dc_i,       // received dot correction codes
    input  wire logic [15:0]         fault_i,           // per-channel led fault
    input  wire logic                startup_i,         // startup phase active
    output logic [15:0]              sink_en_o,         // current sink enables
    output gdp_pkg::gdp_dc_arr_t     dot_correction_code_o, // dac codes
    output logic                     precharge_phase_o, // precharge phase
    output logic                     led_loop_amplifier_en_o,      // led loop in control
    output logic                     feedback_loop_amplifier_sel_o,// feedback loop in control
    output logic                     enable_bit_o,      // current enable bit
    output logic                     frame_select_bit_o // current frame select bit
);
    import gdp_pkg::*;

    gdp_cnt_if cnt_bus();

    gdp_gs_arr_t grayscale_level;
    gdp_gs_arr_t next_grayscale_level;
    gdp_dc_arr_t dc_code;
    gdp_dc_arr_t next_dc_code;
    logic        enable_bit;
    logic        next_enable_bit;
    logic        frame_select_bit;
    logic        next_frame_select_bit;
    logic        dim_prev;
    logic        dim_rise;
    logic [15:0] ch_on;
    logic [15:0] next_ch_on;
    logic        prech;
    logic        next_prech;
    gdp_phase_t  phase;
    logic        all_inactive;

    // configuration registers
    always_comb
    begin
        next_grayscale_level  = grayscale_level;
        next_dc_code          = dc_code;
        next_enable_bit       = enable_bit;
        next_frame_select_bit = frame_select_bit;
        if (load_i)
        begin
            next_enable_bit       = enable_bit_i;          // [R15]
            next_frame_select_bit = frame_select_bit_i;
            if (frame_select_bit_i)
                next_dc_code = frame_dc_i;                 // [R15] [R13]
            else
                next_grayscale_level = frame_gs_i;         // [R15]
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            for (int i = 0; i < `GDP_NUM_CH; i++)
            begin
                grayscale_level[i] <= `GDP_GS_RESET;       // [R14]
                dc_code[i]         <= `GDP_DC_RESET;       // [R14]
            end
            enable_bit       <= 1'b0;                      // [R14]
            frame_select_bit <= 1'b0;                      // [R14]
        end
        else
        begin
            grayscale_level  <= next_grayscale_level;
            dc_code          <= next_dc_code;
            enable_bit       <= next_enable_bit;
            frame_select_bit <= next_frame_select_bit;
        end
    end

    // dimming clock edge detect; clock held still keeps the sink enables frozen
    assign dim_rise = dimming_clock_i && !dim_prev;        // [R8]

    gdp_counter u_counter
    (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .enable_i   (enable_bit),
        .dim_rise_i (dim_rise),
        .cnt        (cnt_bus.ctr)
    );

    // next count value seen on a step
    gdp_gs_t nc;
    assign nc = cnt_bus.count + 12'h001;

    // one comparator per channel against the shared counter
    genvar g;
    generate
        for (g = 0; g < `GDP_NUM_CH; g++)
        begin : g_ch
            always_comb
            begin
                next_ch_on[g] = ch_on[g];
                if (!enable_bit)
                    next_ch_on[g] = 1'b0;                  // [R5]
                else if (cnt_bus.step)
                begin
                    if (nc == grayscale_level[g])
                        next_ch_on[g] = 1'b0;              // [R4]
                    else if (nc == 12'h001 && grayscale_level[g] != 12'h000)
                        next_ch_on[g] = 1'b1;              // [R2] [R16] [R1] [R6]
                end
            end
        end
    endgenerate

    assign all_inactive = ((ch_on & ~fault_i) == 16'h0000) && cnt_bus.running;

    // precharge: high from count 3584 through the wrap to zero, low again when the count steps to one
    always_comb
    begin
        next_prech = prech;
        if (!enable_bit)
            next_prech = 1'b0;
        else if (cnt_bus.step && nc == 12'h001)
            next_prech = 1'b0;                             // [R16]
        else if (cnt_bus.step && nc == `GDP_TRACK_CYCLES)
            next_prech = 1'b1;                             // [R9]
        else if (all_inactive)
            next_prech = 1'b1;                             // [R10]
    end

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            dim_prev <= 1'b0;
            ch_on    <= 16'h0000;
            prech    <= 1'b0;
        end
        else
        begin
            dim_prev <= dimming_clock_i;
            ch_on    <= next_ch_on;
            prech    <= next_prech;
        end
    end

    always_comb
    begin
        if (startup_i)
            phase = GDP_STARTUP;
        else if (prech)
            phase = GDP_PRECHARGE_PHASE;
        else
            phase = GDP_TRACKING;
    end

    always_comb
    begin
        case (phase)
            GDP_TRACKING: led_loop_amplifier_en_o = 1'b1;  // [R11]
            GDP_PRECHARGE_PHASE:   led_loop_amplifier_en_o = 1'b0;  // [R11]
            GDP_STARTUP:  led_loop_amplifier_en_o = 1'b0;  // [R12]
            default:      led_loop_amplifier_en_o = 1'b0;
        endcase
    end

    assign feedback_loop_amplifier_sel_o = !led_loop_amplifier_en_o; // [R11]
    assign sink_en_o             = ch_on;                  // [R7]
    assign dot_correction_code_o = dc_code;                // [R13]
    assign precharge_phase_o     = prech;
    assign enable_bit_o          = enable_bit;
    assign frame_select_bit_o    = frame_select_bit;
endmodule : gdp_top
`default_nettype wire

// ==== tb/gdp_properties.sv ====
// port-level assertions for the dimming generator
`timescale 1ns/100ps
`default_nettype none
module gdp_checker
(
    input wire logic                 core_clk_i,                    // clock
    input wire logic                 resetn_i,                      // reset
    input wire logic                 dimming_clock_i,               // dim clock
    input wire logic                 load_i,                        // load
    input wire logic                 frame_select_bit_i,            // fs in
    input wire logic                 enable_bit_i,                  // en in
    input wire gdp_pkg::gdp_dc_arr_t frame_dc_i,                    // codes in
    input wire logic                 startup_i,                     // startup
    input wire logic [15:0]          sink_en_o,                     // sinks
    input wire gdp_pkg::gdp_dc_arr_t dot_correction_code_o,         // codes
    input wire logic                 precharge_phase_o,             // phase
    input wire logic                 led_loop_amplifier_en_o,       // led loop
    input wire logic                 feedback_loop_amplifier_sel_o, // fb loop
    input wire logic                 enable_bit_o,                  // en
    input wire logic                 frame_select_bit_o             // fs
);
    import gdp_pkg::*;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    // dimming clock held still while enabled
    sequence s_still;
        (enable_bit_o && $stable(dimming_clock_i))[*2];
    endsequence
    AST_EN_OFF: assert property (!enable_bit_o |=> !sink_en_o && !precharge_phase_o)
        else $error("outputs active while disabled");
    AST_HOLD: assert property (s_still |=> !enable_bit_o || $stable(sink_en_o))
        else $error("sinks moved without a dimming edge");
    AST_FB_INV: assert property (feedback_loop_amplifier_sel_o != led_loop_amplifier_en_o)
        else $error("loop selects not complementary");
    AST_LED_LOOP: assert property (!startup_i |->
        led_loop_amplifier_en_o == !precharge_phase_o)
        else $error("led loop not following phase");
    AST_STARTUP: assert property (startup_i |-> !led_loop_amplifier_en_o)
        else $error("led loop on in startup");
    AST_DC_LOAD: assert property (load_i && frame_select_bit_i |=>
        dot_correction_code_o == $past(frame_dc_i))
        else $error("codes not loaded");
    AST_DC_HOLD: assert property (load_i && !frame_select_bit_i |=> $stable(dot_correction_code_o))
        else $error("codes changed by level frame");
    AST_EN_LOAD: assert property (load_i |=> enable_bit_o == $past(enable_bit_i)
        && frame_select_bit_o == $past(frame_select_bit_i))
        else $error("control bits not loaded");
endmodule // gdp_checker
`default_nettype wire

// ==== tb/gdp_ctrl_model.sv ====
// far-side controller model driving the dimming clock
`timescale 1ns/100ps
`default_nettype none
module gdp_ctrl_model
(
    input  wire logic core_clk_i,     // clock
    output var logic  dimming_clock_o // dim clock
);
    initial dimming_clock_o = 1'b0;
    // one dimming edge; idle low and still between calls
    task automatic step(input int hi, input int lo);
        @(posedge core_clk_i);
        #1 dimming_clock_o = 1'b1;
        repeat (hi) @(posedge core_clk_i);
        #1 dimming_clock_o = 1'b0;
        repeat (lo) @(posedge core_clk_i);
        #1;
    endtask
endmodule // gdp_ctrl_model
`default_nettype wire

// ==== tb/grayscale_dimming_precharge_tb_top.sv ====
// testbench for the dimming generator
`timescale 1ns/100ps
`default_nettype none
module grayscale_dimming_precharge_tb_top;
    import gdp_pkg::*;
    logic        core_clk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        load_i = 1'b0;
    logic        frame_select_bit_i = 1'b0;
    logic        enable_bit_i = 1'b0;
    logic        startup_i = 1'b0;
    logic [15:0] fault_i = 16'h0000;
    gdp_gs_arr_t frame_gs_i = '0;
    gdp_dc_arr_t frame_dc_i = '0;
    gdp_dc_arr_t keep;
    wire logic   dimming_clock_i;
    logic [15:0] sink_en_o;
    gdp_dc_arr_t dot_correction_code_o;
    logic        precharge_phase_o, led_loop_amplifier_en_o, feedback_loop_amplifier_sel_o;
    logic        enable_bit_o, frame_select_bit_o;
    int          bad_count = 0;
    int          checked = 0;
    always #2 core_clk_i = ~core_clk_i;
    gdp_ctrl_model CTRL (.core_clk_i, .dimming_clock_o(dimming_clock_i));
    gdp_top DUT (.core_clk_i, .resetn_i, .dimming_clock_i, .load_i, .frame_select_bit_i,
        .enable_bit_i, .frame_gs_i, .frame_dc_i, .fault_i, .startup_i, .sink_en_o,
        .dot_correction_code_o, .precharge_phase_o, .led_loop_amplifier_en_o,
        .feedback_loop_amplifier_sel_o, .enable_bit_o, .frame_select_bit_o);
    task automatic cmp(input logic ok, input string what);
        checked++;
        if (ok !== 1'b1)
        begin
            bad_count++;
            $display("ERROR %0t %s", $time, what);
        end
    endtask
    task automatic load(input logic fs, input logic en);
        @(posedge core_clk_i);
        #1 load_i = 1'b1;
        frame_select_bit_i = fs;
        enable_bit_i = en;
        @(posedge core_clk_i);
        #1 load_i = 1'b0;
    endtask
    // channel on while count is past zero and below its level
    function automatic logic [15:0] exp_sink(input int c);
        for (int i = 0; i < 16; i++)
            exp_sink[i] = (c != 0) && (c < frame_gs_i[i]);
    endfunction
    task automatic t_codes;
        for (int i = 0; i < 16; i++)
            frame_dc_i[i] = 6'(i * 4 + 3);
        keep = frame_dc_i;
        load(1'b1, 1'b0);
        cmp(dot_correction_code_o === keep && frame_select_bit_o === 1'b1, "codes");
        frame_dc_i = '0;
        load(1'b0, 1'b0);
        cmp(dot_correction_code_o === keep, "codes held");
    endtask
    task automatic t_period;
        for (int i = 0; i < 16; i++)
            frame_gs_i[i] = 12'(i * 273);
        load(1'b0, 1'b1);
        cmp(sink_en_o === 16'h0000 && precharge_phase_o === 1'b0, "before step");
        for (int k = 1; k <= 4097; k++)
        begin
            CTRL.step((k % 7 == 0) ? 3 : 1, 1);
            cmp(sink_en_o === exp_sink(k % 4096), "sinks");
            cmp(precharge_phase_o === (k % 4096 >= 3584 || k == 4096), "phase");
        end
        repeat (40) @(posedge core_clk_i);
        cmp(sink_en_o === exp_sink(1), "paused");
    endtask
    task automatic t_clear;
        load(1'b0, 1'b0);
        @(posedge core_clk_i);
        #1 cmp(sink_en_o === 16'h0000 && precharge_phase_o === 1'b0, "clear");
        CTRL.step(1, 1);
        cmp(sink_en_o === 16'h0000, "step while off");
        load(1'b0, 1'b1);
        CTRL.step(1, 1);
        cmp(sink_en_o === exp_sink(1), "first step");
    endtask
    // startup checked while tracking, so only startup can turn the led loop off
    task automatic t_inactive;
        startup_i = 1'b1;
        #1 cmp(!led_loop_amplifier_en_o && feedback_loop_amplifier_sel_o === 1'b1, "startup");
        @(posedge core_clk_i);
        #1 startup_i = 1'b0;
        fault_i = 16'hFFFF;
        #1 cmp(led_loop_amplifier_en_o === 1'b1 && precharge_phase_o === 1'b0, "tracking");
        repeat (2) @(posedge core_clk_i);
        #1 cmp(precharge_phase_o === 1'b1 && led_loop_amplifier_en_o === 1'b0, "early");
    endtask
    task automatic print_verdict;
        if (bad_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge core_clk_i);
        #1 resetn_i = 1'b1;
        cmp(sink_en_o === 16'h0000 && dot_correction_code_o === '0 && enable_bit_o === 1'b0
            && frame_select_bit_o === 1'b0, "reset");
        t_codes();
        t_period();
        t_clear();
        t_inactive();
        print_verdict();
    end
endmodule // grayscale_dimming_precharge_tb_top
bind gdp_top gdp_checker CHK (.core_clk_i, .resetn_i, .dimming_clock_i, .load_i,
    .frame_select_bit_i, .enable_bit_i, .frame_dc_i, .startup_i, .sink_en_o,
    .dot_correction_code_o, .precharge_phase_o, .led_loop_amplifier_en_o,
    .feedback_loop_amplifier_sel_o, .enable_bit_o, .frame_select_bit_o);
`default_nettype wire
